// ===== prs_consts.svh
// Constants of the program store sequencer.
`ifndef PRS_CONSTS_SVH
`define PRS_CONSTS_SVH
`define PRS_AW          11
`define PRS_DW          16
`define PRS_STK_DEPTH   5
`define PRS_SP_W        3
`define PRS_VEC_RESET   11'h000
`define PRS_VEC_SERIAL  11'h001
`define PRS_VEC_TIMER   11'h002
`define PRS_VEC_EXT     11'h003
`define PRS_OPR_LSB     0
`define PRS_OPR_MSB     10
`endif

// ===== prs_pkg.sv
// Types of the program store sequencer.
package prs_pkg;
    // Flow command from the instruction decoder.
    typedef enum logic [2:0] {
        PRS_CMD_SEQ,
        PRS_CMD_JMP_DIR,
        PRS_CMD_JMP_IND,
        PRS_CMD_CALL_DIR,
        PRS_CMD_CALL_IND,
        PRS_CMD_RET,
        PRS_CMD_TABLE
    } prs_cmd_t;
    // Interrupt source selector.
    typedef enum logic [1:0] {
        PRS_IRQ_SERIAL,
        PRS_IRQ_TIMER,
        PRS_IRQ_EXT
    } prs_irq_t;
endpackage

// ===== prs_addr_stack.sv
// Five-entry address stack of the program store sequencer.
`include "prs_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module prs_addr_stack (
    // Clock and reset.
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // Stack operations.
    input  wire logic                  push,
    input  wire logic                  pop,
    input  wire logic [`PRS_AW-1:0]    push_addr,
    // Stack state.
    output logic      [`PRS_AW-1:0]    top_addr,
    output logic      [`PRS_SP_W-1:0]  depth
);
    logic [`PRS_AW-1:0]   entry_ff [`PRS_STK_DEPTH];
    logic [`PRS_SP_W-1:0] sp_ff;
    logic [`PRS_SP_W-1:0] nxt_sp;
    wire                  do_push = push && !pop;
    wire                  do_pop  = pop && !push && (sp_ff != 3'h0);

    // Pointer moves up on push and down on pop; full stack wraps.
    assign nxt_sp = do_push ? ((sp_ff == 3'h5) ? 3'h0 : sp_ff + 3'h1)
                  : do_pop ? sp_ff - 3'h1 : sp_ff;
    assign top_addr = entry_ff[(sp_ff == 3'h0) ? 3'h0 : sp_ff - 3'h1];
    assign depth    = sp_ff;

    // Pointer register.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sp_ff <= 3'h0;
        end else begin
            sp_ff <= nxt_sp;
        end
    end

    // One write port per entry, selected by the pointer.
    genvar gi;
    generate
        for (gi = 0; gi < `PRS_STK_DEPTH; gi++) begin : g_ent
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    entry_ff[gi] <= 11'h000;
                end else if (do_push && sp_ff == 3'(gi)) begin
                    entry_ff[gi] <= push_addr;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ===== prs_sequencer.sv
// Program store sequencer: next-address choice, fetch and table read.
// Functional notes
// - Indirect jumps, indirect calls and table reads reach any word 0000H to 07FFH; direct ones reach 0000H to 03FFH.
// - Each instruction is one 16-bit store word per fetch.
// - Flow is ascending one word at a time, starting at 0000H.
// - Program store is read-only; no write path exists.
// - Reset loads counter with 0000H and fetching starts there.
// - Interrupt vectors: serial 0001H, timer 0002H, external 0003H.
// - Direct jump loads counter from 11-bit operand, top bit zero.
// - Indirect jump loads counter from the pointer register.
// - Direct call target is the 11-bit operand, top bit zero.
// - Indirect call target is the pointer register value.
// - Table fetch reads store word at pointer into fetch buffer.
// - Table fetch moves all 16 bits into the fetch buffer.
// - Table fetch holds one stack level, then frees it.
// - Table fetch takes two cycles; others take one.
// - Calls push the counter plus one onto the stack before loading target.
// - Returns restore the counter from the stack top entry.
// - Accepted interrupt saves counter plus one on stack, then loads vector.
// - Address stack has five entries as wide as the counter.
`include "prs_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module prs_sequencer (
    // Clock and reset.
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // Decoder command.
    input  wire prs_pkg::prs_cmd_t     cmd,
    input  wire logic                  irq_accept,
    input  wire prs_pkg::prs_irq_t     irq_src,
    // Pointer register nibbles.
    input  wire logic [3:0]            pointer_register_n3,
    input  wire logic [3:0]            pointer_register_n2,
    input  wire logic [3:0]            pointer_register_n1,
    input  wire logic [3:0]            pointer_register_n0,
    // Program store port.
    output logic      [`PRS_AW-1:0]    rom_addr,
    input  wire logic [`PRS_DW-1:0]    rom_data,
    // Decoder side.
    output logic      [`PRS_DW-1:0]    instr_word,
    output logic                       instr_valid,
    output logic      [`PRS_AW-1:0]    instr_counter,
    output logic                       busy,
    // Fetch buffer write.
    output logic      [3:0]            fetch_buffer_n3,
    output logic      [3:0]            fetch_buffer_n2,
    output logic      [3:0]            fetch_buffer_n1,
    output logic      [3:0]            fetch_buffer_n0,
    output logic                       fetch_buffer_we,
    // Stack status.
    output logic      [`PRS_SP_W-1:0]  stack_depth
);
    typedef enum logic [1:0] {PRS_ST_RUN, PRS_ST_TBL} prs_state_t;
    prs_state_t           state_ff;
    prs_state_t           nxt_state;
    logic [`PRS_AW-1:0]   pc_ff, nxt_pc, addr_ff, nxt_addr;
    logic [`PRS_DW-1:0]   iw_ff;
    logic                 iv_ff, tbl_we_ff;
    logic [`PRS_DW-1:0]   fb_ff;
    logic [`PRS_SP_W-1:0] dep_ff;
    logic [`PRS_AW-1:0]   stk_top;
    logic [`PRS_SP_W-1:0] stk_depth;
    logic [15:0]          ptr_full;
    logic [`PRS_AW-1:0]   ptr, opr, vec, pc_inc;
    logic                 run, push, pop;

    // ==================================================================
    // Address selection.
    // ==================================================================
    // Pointer assembled from nibbles, highest nibble on top.
    assign ptr_full = {pointer_register_n3, pointer_register_n2,
                       pointer_register_n1, pointer_register_n0};
    assign ptr    = ptr_full[`PRS_AW-1:0];
    assign opr    = {1'b0, iw_ff[`PRS_OPR_MSB-1:`PRS_OPR_LSB]};
    assign pc_inc = pc_ff + 11'h001;
    assign run    = (state_ff == PRS_ST_RUN);
    // Vector chosen by source.
    assign vec = (irq_src == prs_pkg::PRS_IRQ_SERIAL) ? `PRS_VEC_SERIAL
               : (irq_src == prs_pkg::PRS_IRQ_TIMER)  ? `PRS_VEC_TIMER
               : `PRS_VEC_EXT;
    // Interrupts, calls and table fetch push; returns and table end pop.
    assign push = run && (irq_accept
                || cmd == prs_pkg::PRS_CMD_CALL_DIR
                || cmd == prs_pkg::PRS_CMD_CALL_IND
                || cmd == prs_pkg::PRS_CMD_TABLE);
    assign pop  = (!run) || (!irq_accept && cmd == prs_pkg::PRS_CMD_RET);

    // Next counter: table end restore first, then interrupt, then the decoded command.
    always_comb begin
        nxt_pc    = pc_inc;
        nxt_state = state_ff;
        nxt_addr  = pc_inc;
        if (!run) begin
            nxt_pc    = stk_top;
            nxt_state = PRS_ST_RUN;
        end else if (irq_accept) begin
            nxt_pc = vec;
        end else begin
            case (cmd)
                prs_pkg::PRS_CMD_JMP_DIR:  nxt_pc = opr;
                prs_pkg::PRS_CMD_JMP_IND:  nxt_pc = ptr;
                prs_pkg::PRS_CMD_CALL_DIR: nxt_pc = opr;
                prs_pkg::PRS_CMD_CALL_IND: nxt_pc = ptr;
                prs_pkg::PRS_CMD_RET:      nxt_pc = stk_top;
                prs_pkg::PRS_CMD_TABLE: begin
                    nxt_pc    = pc_ff;
                    nxt_state = PRS_ST_TBL;
                end
                default:                   nxt_pc = pc_inc;
            endcase
        end
        nxt_addr = (nxt_state == PRS_ST_TBL) ? ptr : nxt_pc;
    end

    // ==================================================================
    // Registers.
    // ==================================================================
    // Counter, store address and state; store is only ever read.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pc_ff    <= `PRS_VEC_RESET;
            addr_ff  <= `PRS_VEC_RESET;
            state_ff <= PRS_ST_RUN;
        end else begin
            pc_ff    <= nxt_pc;
            addr_ff  <= nxt_addr;
            state_ff <= nxt_state;
        end
    end

    // Captured instruction word and table word.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            iw_ff     <= 16'h0000;
            iv_ff     <= 1'b0;
            fb_ff     <= 16'h0000;
            tbl_we_ff <= 1'b0;
            dep_ff    <= 3'h0;
        end else begin
            iw_ff     <= run ? rom_data : 16'h0000;
            iv_ff     <= run;
            fb_ff     <= run ? fb_ff : rom_data;
            tbl_we_ff <= !run;
            dep_ff    <= stk_depth;
        end
    end

    prs_addr_stack u_stack (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .push      (push),
        .pop       (pop),
        .push_addr (run ? (cmd == prs_pkg::PRS_CMD_TABLE && !irq_accept
                           ? pc_inc : pc_inc) : pc_ff),
        .top_addr  (stk_top),
        .depth     (stk_depth)
    );

    // ==================================================================
    // Outputs.
    // ==================================================================
    assign rom_addr        = addr_ff;
    assign instr_word      = iw_ff;
    assign instr_valid     = iv_ff;
    assign instr_counter   = pc_ff;
    assign busy            = (state_ff == PRS_ST_TBL);
    assign fetch_buffer_n3 = fb_ff[15:12];
    assign fetch_buffer_n2 = fb_ff[11:8];
    assign fetch_buffer_n1 = fb_ff[7:4];
    assign fetch_buffer_n0 = fb_ff[3:0];
    assign fetch_buffer_we = tbl_we_ff;
    assign stack_depth     = dep_ff;

    // ==================================================================
    // Assertions.
    // ==================================================================
    a_reset_vector: assert property (@(posedge clk)
        sys_rst |=> pc_ff == 11'h000) else $error("reset vector wrong");
    a_seq_step: assert property (@(posedge clk) disable iff (sys_rst)
        run && !irq_accept && cmd == prs_pkg::PRS_CMD_SEQ
        |=> pc_ff == $past(pc_ff) + 11'h001) else $error("no step");
    a_irq_vec: assert property (@(posedge clk) disable iff (sys_rst)
        run && irq_accept |=> pc_ff <= 11'h003 && pc_ff != 11'h000)
        else $error("bad vector");
    a_jmp_ind: assert property (@(posedge clk) disable iff (sys_rst)
        run && !irq_accept && cmd == prs_pkg::PRS_CMD_JMP_IND
        |=> pc_ff == $past(ptr)) else $error("indirect jump wrong");
    a_jmp_dir: assert property (@(posedge clk) disable iff (sys_rst)
        run && !irq_accept && cmd == prs_pkg::PRS_CMD_JMP_DIR
        |=> pc_ff[10] == 1'b0 && pc_ff[9:0] == $past(iw_ff[9:0]))
        else $error("direct jump target wrong");
    a_table_two: assert property (@(posedge clk) disable iff (sys_rst)
        run && !irq_accept && cmd == prs_pkg::PRS_CMD_TABLE
        |=> busy ##1 !busy) else $error("table not two cycles");
    a_table_stack: assert property (@(posedge clk)
        disable iff (sys_rst)
        run && !irq_accept && cmd == prs_pkg::PRS_CMD_TABLE
        && stk_depth < 3'h4 |=> ##1 stk_depth == $past(stk_depth, 2))
        else $error("table stack level not freed");
    a_table_buf: assert property (@(posedge clk)
        disable iff (sys_rst)
        busy |=> fetch_buffer_we && fb_ff == $past(rom_data))
        else $error("buffer not loaded");
    a_call_push: assert property (@(posedge clk)
        disable iff (sys_rst)
        run && !irq_accept && cmd == prs_pkg::PRS_CMD_CALL_DIR
        && stk_depth < 3'h4 |=> stk_depth == $past(stk_depth) + 3'h1)
        else $error("call did not push");
    a_ret_restore: assert property (@(posedge clk)
        disable iff (sys_rst)
        run && !irq_accept && cmd == prs_pkg::PRS_CMD_RET
        && stk_depth != 3'h0 |=> pc_ff == $past(stk_top))
        else $error("return did not restore counter");
    a_irq_push: assert property (@(posedge clk)
        disable iff (sys_rst)
        run && irq_accept && stk_depth < 3'h5
        |=> stk_depth == $past(stk_depth) + 3'h1)
        else $error("interrupt did not save counter");
    a_call_ind: assert property (@(posedge clk)
        disable iff (sys_rst)
        run && !irq_accept && cmd == prs_pkg::PRS_CMD_CALL_IND
        |=> pc_ff == $past(ptr)) else $error("indirect call wrong");
    c_full: cover property (@(posedge clk) stk_depth == 3'h5);
    c_table: cover property (@(posedge clk) busy ##1 fetch_buffer_we);
    c_irq: cover property (@(posedge clk) run && irq_accept);
    c_ret: cover property (@(posedge clk)
        run && cmd == prs_pkg::PRS_CMD_RET && stk_depth != 3'h0);
endmodule
`default_nettype wire

// ===== prs_rom_model.sv
// Behavioural program store that answers the sequencer's reads.
`include "prs_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module prs_rom_model (
    // Store port.
    input  wire logic [`PRS_AW-1:0] addr,
    output logic      [`PRS_DW-1:0] data
);
    // ========================================
    // Read path
    // One whole 16-bit word per address, with no write path at all.
    // The operand field is the inverted low ten address bits, bit 10 clear.
    assign data = {5'h15, 1'b0, ~addr[9:0]};
endmodule
`default_nettype wire

// ===== test_program_rom_sequencer.sv
// Self-checking bench of the program store sequencer.
`include "prs_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module test_program_rom_sequencer;
    // ========================================
    // Signals
    logic clk, sys_rst, irq_accept, busy, we, valid;
    prs_pkg::prs_cmd_t cmd;
    prs_pkg::prs_irq_t irq_src;
    logic [15:0] ptr, iw, exp_iw;
    logic [10:0] ra, pc, exp_pc;
    wire logic [15:0] rd, fb;
    logic [2:0] depth;
    logic [10:0] stk[$];
    int fails, compares;
    prs_sequencer prs_sequencer_inst (.clk(clk), .sys_rst(sys_rst),
        .cmd(cmd), .irq_accept(irq_accept), .irq_src(irq_src),
        .pointer_register_n3(ptr[15:12]), .pointer_register_n2(ptr[11:8]),
        .pointer_register_n1(ptr[7:4]), .pointer_register_n0(ptr[3:0]),
        .rom_addr(ra), .rom_data(rd), .instr_word(iw), .instr_valid(valid),
        .instr_counter(pc), .busy(busy), .fetch_buffer_n3(fb[15:12]),
        .fetch_buffer_n2(fb[11:8]), .fetch_buffer_n1(fb[7:4]),
        .fetch_buffer_n0(fb[3:0]), .fetch_buffer_we(we),
        .stack_depth(depth));
    prs_rom_model prs_rom_model_inst (.addr(ra), .data(rd));
    // ========================================
    // Helpers
    // Expected store word, worked out apart from the model.
    function automatic logic [15:0] word_at(input logic [10:0] a);
        return {5'h15, 1'b0, ~a[9:0]};
    endfunction
    task automatic check(input string what, input logic [15:0] got,
                         input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Issues one command at a falling edge and tracks counter and word.
    // The command belongs to the word now shown, fetched one edge before.
    task automatic issue(input prs_pkg::prs_cmd_t c);
        logic [15:0] nxt_iw;
        nxt_iw = word_at(exp_pc);
        case (c)
            prs_pkg::PRS_CMD_JMP_DIR: exp_pc = exp_iw[10:0];
            prs_pkg::PRS_CMD_JMP_IND: exp_pc = ptr[10:0];
            prs_pkg::PRS_CMD_CALL_DIR: begin
                stk.push_back(exp_pc + 11'h001);
                exp_pc = exp_iw[10:0];
            end
            prs_pkg::PRS_CMD_CALL_IND: begin
                stk.push_back(exp_pc + 11'h001);
                exp_pc = ptr[10:0];
            end
            prs_pkg::PRS_CMD_RET: exp_pc = stk.pop_back();
            default: exp_pc = exp_pc + 11'h001;
        endcase
        cmd = c;
        @(negedge clk);
        exp_iw = nxt_iw;
        check("counter", {5'h00, pc}, {5'h00, exp_pc});
        check("word", iw, exp_iw);
        check("valid", {15'h0000, valid}, 16'h0001);
    endtask
    // ========================================
    // Scenarios
    task automatic t_reset();
        check("reset counter", {5'h00, pc}, 16'h0000);
        check("reset depth", {13'h0000, depth}, 16'h0000);
        check("reset valid", {15'h0000, valid}, 16'h0000);
        repeat (3) issue(prs_pkg::PRS_CMD_SEQ);
        check("third word", iw, word_at(11'h002));
        $display("test reset and sequence done");
    endtask
    task automatic t_flow();
        issue(prs_pkg::PRS_CMD_JMP_DIR);
        ptr = 16'hf7ff;
        issue(prs_pkg::PRS_CMD_JMP_IND);
        issue(prs_pkg::PRS_CMD_CALL_DIR);
        ptr = 16'h0000;
        issue(prs_pkg::PRS_CMD_CALL_IND);
        for (int i = 0; i < 3; i++) issue(prs_pkg::PRS_CMD_CALL_DIR);
        issue(prs_pkg::PRS_CMD_SEQ);
        check("full depth", {13'h0000, depth}, 16'h0005);
        repeat (5) issue(prs_pkg::PRS_CMD_RET);
        issue(prs_pkg::PRS_CMD_SEQ);
        check("empty depth", {13'h0000, depth}, 16'h0000);
        $display("test jumps calls returns done");
    endtask
    task automatic t_irq();
        logic [10:0] vec[3];
        vec = '{`PRS_VEC_SERIAL, `PRS_VEC_TIMER, `PRS_VEC_EXT};
        for (int i = 0; i < 3; i++) begin
            irq_src = prs_pkg::prs_irq_t'(i);
            irq_accept = 1'b1;
            cmd = prs_pkg::PRS_CMD_JMP_DIR;
            stk.push_back(exp_pc + 11'h001);
            @(negedge clk);
            irq_accept = 1'b0;
            exp_iw = word_at(exp_pc);
            exp_pc = vec[i];
            check("vector", {5'h00, pc}, {5'h00, vec[i]});
            issue(prs_pkg::PRS_CMD_SEQ);
            check("irq depth", {13'h0000, depth}, 16'h0001);
            issue(prs_pkg::PRS_CMD_RET);
            ptr = 16'h0123;
            issue(prs_pkg::PRS_CMD_JMP_IND);
            check("irq pop", {13'h0000, depth}, 16'h0000);
        end
        $display("test interrupts done");
    endtask
    task automatic t_table();
        ptr = 16'hf5a3;
        cmd = prs_pkg::PRS_CMD_TABLE;
        @(negedge clk);
        check("busy", {15'h0000, busy}, 16'h0001);
        check("held counter", {5'h00, pc}, {5'h00, exp_pc});
        cmd = prs_pkg::PRS_CMD_JMP_DIR;
        @(negedge clk);
        exp_pc = exp_pc + 11'h001;
        exp_iw = 16'h0000;
        check("busy end", {15'h0000, busy}, 16'h0000);
        check("table valid", {15'h0000, valid}, 16'h0000);
        check("buffer we", {15'h0000, we}, 16'h0001);
        check("buffer", fb, word_at(11'h5a3));
        check("stack held", {13'h0000, depth}, 16'h0001);
        check("restored counter", {5'h00, pc}, {5'h00, exp_pc});
        issue(prs_pkg::PRS_CMD_SEQ);
        check("we pulse", {15'h0000, we}, 16'h0000);
        issue(prs_pkg::PRS_CMD_SEQ);
        check("table depth", {13'h0000, depth}, 16'h0000);
        $display("test table fetch done");
    endtask
    // ========================================
    // Verdict
    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Clock of 20 ns period.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Main sequence with a ten cycle reset.
    initial begin
        sys_rst = 1'b1;
        cmd = prs_pkg::PRS_CMD_SEQ;
        irq_accept = 1'b0;
        irq_src = prs_pkg::PRS_IRQ_SERIAL;
        ptr = 16'h0000;
        exp_pc = 11'h000;
        exp_iw = 16'h0000;
        fails = 0;
        compares = 0;
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        t_reset();
        t_flow();
        t_irq();
        t_table();
        end_of_test();
    end
    // Watchdog far beyond the few dozen cycles the tests need.
    initial begin
        #100000;
        fails++;
        end_of_test();
    end
endmodule
`default_nettype wire
